// ==== hw/mprs_low_timer.sv ====
// Low-pulse timer: counts cycles a synchronised active-low line stays low.
// Assumes line_low is already synchronised to clk.
`timescale 1ns/100ps
module mprs_low_timer #(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             line_low,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  reached,
  output logic                  released_long
);

  logic [CNT_W-1:0] cnt_q;
  logic             hit_q;
  logic [CNT_W-1:0] cnt_d;
  logic             hit_d;
  logic             cnt_top;

  // Saturate so a held line never wraps into a false short pulse
  assign cnt_top       = (cnt_q == {CNT_W{1'b1}});
  assign cnt_d         = !line_low ? '0 : (cnt_top ? cnt_q : cnt_q + 1'b1);
  assign hit_d         = line_low & (hit_q | (cnt_d >= limit));
  assign reached       = hit_q;
  assign released_long = hit_q & !line_low;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      hit_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      hit_q <= hit_d;
    end
  end

endmodule : mprs_low_timer

// ==== hw/mprs_pkg.sv ====
// Package: states and timing constants of the module power/restart sequencer.
// Assumes a 100 MHz system clock; long counts are overridden at the top level.
package mprs_pkg;

  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned ON_PULSE_MS   = 1000;
  localparam int unsigned OFF_PULSE_MS  = 3000;
  localparam int unsigned RST_PULSE_MS  = 200;
  localparam int unsigned GUARD_MS      = 200;
  localparam int unsigned DETACH_MS     = 10;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;

  localparam int unsigned ON_CYCLES     = ON_PULSE_MS * MS_CYCLES;
  localparam int unsigned OFF_CYCLES    = OFF_PULSE_MS * MS_CYCLES;
  localparam int unsigned RST_CYCLES    = RST_PULSE_MS * MS_CYCLES;
  localparam int unsigned GUARD_CYCLES  = GUARD_MS * MS_CYCLES;
  localparam int unsigned DETACH_CYCLES = DETACH_MS * MS_CYCLES;

  localparam int unsigned CNT_W         = 32;

  typedef enum logic [2:0] {
    MPRS_OFF     = 3'b000,
    MPRS_BOOT    = 3'b001,
    MPRS_ON      = 3'b010,
    MPRS_DETACH  = 3'b011,
    MPRS_RESTART = 3'b100
  } mprs_state_t;

endpackage : mprs_pkg

// ==== hw/mprs_sequencer.sv ====
// Module power/restart sequencer: toggle and restart pins, power-good, detach, flow control.
// Assumes open-drain pins pulled up externally to this logic; pins are asynchronous.
//
// Contract
// - Turn-off issues network detach request first
// - Power-good stays high while powered on
// - Power-good low once powered off
// - Module drives CTS, host drives RTS
// - Two UARTs; main has two flow signals
`timescale 1ns/100ps
module mprs_sequencer #(
  parameter int unsigned ON_CYCLES     = mprs_pkg::ON_CYCLES,
  parameter int unsigned OFF_CYCLES    = mprs_pkg::OFF_CYCLES,
  parameter int unsigned RST_CYCLES    = mprs_pkg::RST_CYCLES,
  parameter int unsigned GUARD_CYCLES  = mprs_pkg::GUARD_CYCLES,
  parameter int unsigned DETACH_CYCLES = mprs_pkg::DETACH_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic power_toggle_n,
  input  wire logic restart_n,
  input  wire logic detach_done,
  input  wire logic core_rx_ready,
  input  wire logic main_port_request_to_send_in,
  output logic      power_good_indicator,
  output logic      detach_request,
  output logic      core_enable,
  output logic      serial_ready,
  output logic      main_port_clear_to_send_out,
  output logic      core_may_send
);

  localparam int unsigned CW = mprs_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers (first stage read only by the second)
  // Reset to the pulled-up idle level, so leaving reset is no false press
  logic [1:0] tog_sync_q;
  logic [1:0] rst_sync_q;
  logic [1:0] rts_sync_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tog_sync_q <= 2'h3;
      rst_sync_q <= 2'h3;
      rts_sync_q <= 2'h3;
    end
    else
    begin
      tog_sync_q <= {tog_sync_q[0], power_toggle_n};
      rst_sync_q <= {rst_sync_q[0], restart_n};
      rts_sync_q <= {rts_sync_q[0], main_port_request_to_send_in};
    end
  end

  wire tog_low = !tog_sync_q[1];
  wire rst_low = !rst_sync_q[1];
  wire rts_n   = rts_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pulse timers
  mprs_pkg::mprs_state_t state_q;
  mprs_pkg::mprs_state_t state_d;
  logic [CW-1:0]         tog_limit;
  logic                  tog_done;
  logic                  rst_hit;

  // Off needs a one second pulse to start, on needs three to stop
  assign tog_limit = (state_q == mprs_pkg::MPRS_OFF) ? CW'(ON_CYCLES) : CW'(OFF_CYCLES);

  mprs_low_timer #(.CNT_W(CW)) u_tog_timer (
    .clk           (clk),
    .rst_n         (rst_n),
    .line_low      (tog_low),
    .limit         (tog_limit),
    .reached       (),
    .released_long (tog_done)
  );

  // Restart acts on reaching the count, so its release strobe is left open
  mprs_low_timer #(.CNT_W(CW)) u_rst_timer (
    .clk           (clk),
    .rst_n         (rst_n),
    .line_low      (rst_low),
    .limit         (CW'(RST_CYCLES)),
    .reached       (rst_hit),
    .released_long ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  // One countdown serves both guard and detach windows; zero means idle
  logic [CW-1:0] tmr_q;
  logic [CW-1:0] tmr_d;
  wire           tmr_zero = (tmr_q == '0);

  always_comb
  begin
    state_d = state_q;
    tmr_d   = tmr_zero ? tmr_q : tmr_q - 1'b1;
    unique case (state_q)
      mprs_pkg::MPRS_OFF:
      begin
        if (tog_done)
        begin
          state_d = mprs_pkg::MPRS_BOOT;
          tmr_d   = CW'(GUARD_CYCLES);
        end
      end
      mprs_pkg::MPRS_BOOT:
      begin
        if (tmr_zero)
          state_d = mprs_pkg::MPRS_ON;
        else if (tog_done)
        begin
          state_d = mprs_pkg::MPRS_DETACH;
          tmr_d   = CW'(DETACH_CYCLES);
        end
      end
      mprs_pkg::MPRS_ON:
      begin
        if (tog_done)
        begin
          state_d = mprs_pkg::MPRS_DETACH;
          tmr_d   = CW'(DETACH_CYCLES);
        end
      end
      mprs_pkg::MPRS_DETACH:
      begin
        // Detach is bounded so a silent network cannot block power-off
        if (detach_done || tmr_zero)
          state_d = mprs_pkg::MPRS_OFF;
      end
      mprs_pkg::MPRS_RESTART:
      begin
        // A held restart keeps the module dark; power returns on release
        if (!rst_low)
        begin
          state_d = mprs_pkg::MPRS_BOOT;
          tmr_d   = CW'(GUARD_CYCLES);
        end
      end
      default:
        state_d = mprs_pkg::MPRS_OFF;
    endcase
    // Restart overrides everything outside OFF and RESTART and skips the detach
    if (rst_hit && state_q != mprs_pkg::MPRS_OFF && state_q != mprs_pkg::MPRS_RESTART)
      state_d = mprs_pkg::MPRS_RESTART;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= mprs_pkg::MPRS_OFF;
      tmr_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Level outputs except core_may_send leave flops, so pins never glitch while the state settles
  logic pg_q;
  logic det_q;
  logic cts_q;
  logic en_q;
  logic rdy_q;

  wire pg_d  = (state_d != mprs_pkg::MPRS_OFF) && (state_d != mprs_pkg::MPRS_RESTART);
  wire rdy_d = (state_d == mprs_pkg::MPRS_ON);
  // Request stands for the whole detach window, timeout included
  wire det_d = (state_d == mprs_pkg::MPRS_DETACH);
  // CTS active low: asserted only when powered, past guard, and core can take data
  wire cts_d = !(rdy_d && core_rx_ready);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_q  <= 1'b0;
      det_q <= 1'b0;
      cts_q <= 1'b1;
      en_q  <= 1'b0;
      rdy_q <= 1'b0;
    end
    else
    begin
      pg_q  <= pg_d;
      det_q <= det_d;
      cts_q <= cts_d;
      en_q  <= pg_d;
      rdy_q <= rdy_d;
    end
  end

  assign power_good_indicator        = pg_q;
  assign detach_request              = det_q;
  assign core_enable                 = en_q;
  assign serial_ready                = rdy_q;
  assign main_port_clear_to_send_out = cts_q;
  // Open RTS floats high, so the core sees no permission and uses software flow
  assign core_may_send               = rdy_q && !rts_n;

endmodule : mprs_sequencer

// ==== test/mprs_host.sv ====
// Host model: open-drain toggle and restart lines, timed on the clock it shares with the sequencer.
// Assumes the pins are pulled up, so a released line reads high.
`timescale 1ns/100ps
module mprs_host (
  input  wire logic clk,
  output logic      toggle_n,
  output logic      restart_n
);
  initial
  begin
    toggle_n = 1'b1;
    restart_n = 1'b1;
  end
  // Blocking call: no second request can start mid-pulse
  task automatic pulse(input bit rst, input int cycles);
    @(posedge clk);
    if (rst)
      restart_n <= 1'b0;
    else
      toggle_n <= 1'b0;
    repeat (cycles) @(posedge clk);
    toggle_n <= 1'b1;
    restart_n <= 1'b1;
  endtask : pulse
endmodule : mprs_host

// ==== test/mprs_sequencer_asserts.sv ====
// Checker: port relations of the sequencer.
// Assumes only the sequencer's ports; bound below.
`timescale 1ns/100ps
module mprs_sequencer_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_toggle_n,
  input wire logic restart_n,
  input wire logic detach_done,
  input wire logic core_rx_ready,
  input wire logic main_port_request_to_send_in,
  input wire logic power_good_indicator,
  input wire logic detach_request,
  input wire logic core_enable,
  input wire logic serial_ready,
  input wire logic main_port_clear_to_send_out,
  input wire logic core_may_send
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_detach_while_on:
    assert property (detach_request |-> power_good_indicator && !serial_ready) else $error("detach while off");
  a_ready_needs_pg:
    assert property (serial_ready |-> power_good_indicator && core_enable) else $error("ready without power");
  a_detach_ends_off:
    assert property (detach_request && detach_done |=> !power_good_indicator) else $error("still on after detach");
  a_cts_needs_ready:
    assert property (!main_port_clear_to_send_out |-> serial_ready) else $error("cts low while not ready");
  a_send_needs_ready:
    assert property (core_may_send |-> serial_ready) else $error("send while not ready");
  a_send_follows_rts:
    assert property (core_may_send == (serial_ready && !$past(main_port_request_to_send_in, 2)))
      else $error("send permission does not follow rts");
  a_cts_follows_rx:
    assert property ((!main_port_clear_to_send_out) == (serial_ready && $past(core_rx_ready)))
      else $error("cts does not follow core readiness");
  a_pg_is_enable:
    assert property (core_enable == power_good_indicator) else $error("core enable differs from power good");
  a_off_is_quiet:
    assert property (!power_good_indicator |-> !detach_request && !serial_ready && main_port_clear_to_send_out)
      else $error("activity while powered off");
endmodule : mprs_sequencer_asserts
bind mprs_sequencer mprs_sequencer_asserts i_mprs_sequencer_asserts (.*);

// ==== test/mprs_sequencer_test.sv ====
// Testbench: host model plus expected levels worked out from the pulse rules.
// Assumes shortened counts; whole run well under 5000 cycles.
`timescale 1ns/100ps
module mprs_sequencer_test;
  localparam int ON = 20, OFF = 60, RST = 10, GRD = 15, DET = 8;
  logic clk, rst_n, done, rx_rdy, rts_n, tog_n, rs_n;
  logic pg, det, en, rdy, cts_n, send;
  int   num_errors, compares, cycles;
  mprs_host i_mprs_host (.clk(clk), .toggle_n(tog_n), .restart_n(rs_n));
  mprs_sequencer #(.ON_CYCLES(ON), .OFF_CYCLES(OFF), .RST_CYCLES(RST), .GUARD_CYCLES(GRD),
    .DETACH_CYCLES(DET)) i_mprs_sequencer (.clk(clk), .rst_n(rst_n), .power_toggle_n(tog_n),
    .restart_n(rs_n), .detach_done(done), .core_rx_ready(rx_rdy), .main_port_request_to_send_in(rts_n),
    .power_good_indicator(pg), .detach_request(det), .core_enable(en), .serial_ready(rdy),
    .main_port_clear_to_send_out(cts_n), .core_may_send(send));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic exp, input logic seen);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask : check
  // Bounded wait, so a dead output shows as a mismatch not a hang
  task automatic wait_for(ref logic s, input logic v);
    for (int n = 0; n < 40 && s !== v; n++) @(posedge clk);
  endtask : wait_for
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic turn_on();
    i_mprs_host.pulse(0, ON + 2);
    wait_for(pg, 1'b1);
    check("pg_on", 1'b1, pg);
    check("core_enable", 1'b1, en);
    check("ready_at_pg", 1'b0, rdy);
    repeat (GRD - 2) @(posedge clk);
    check("ready_in_guard", 1'b0, rdy);
    repeat (6) @(posedge clk);
    check("serial_ready", 1'b1, rdy);
  endtask : turn_on
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    done = 1'b0;
    rx_rdy = 1'b1;
    rts_n = 1'b0;
    void'($urandom(32'h8f0a));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("pg_reset", 1'b0, pg);
    i_mprs_host.pulse(0, ON / 2);
    i_mprs_host.pulse(1, RST + 4);
    repeat (10) @(posedge clk);
    check("pg_refused", 1'b0, pg);
    turn_on();
    for (int i = 0; i < 8; i++)
    begin
      rx_rdy <= 1'($urandom);
      rts_n <= 1'($urandom);
      repeat (5) @(posedge clk);
      check("cts", ~rx_rdy, cts_n);
      check("may_send", ~rts_n, send);
    end
    rts_n <= 1'b0;
    fork
      i_mprs_host.pulse(1, RST + 10);
      begin
        repeat (RST + 9) @(posedge clk);
        check("pg_restart", 1'b0, pg);
        check("no_detach", 1'b0, det);
        check("ready_restart", 1'b0, rdy);
      end
    join
    wait_for(pg, 1'b1);
    check("pg_reboot", 1'b1, pg);
    repeat (GRD + 4) @(posedge clk);
    i_mprs_host.pulse(0, OFF + 2);
    wait_for(det, 1'b1);
    check("detach", 1'b1, det);
    check("pg_detach", 1'b1, pg);
    check("ready_detach", 1'b0, rdy);
    check("cts_detach", 1'b1, cts_n);
    done <= 1'b1;
    repeat (2) @(posedge clk);
    check("pg_off", 1'b0, pg);
    check("detach_off", 1'b0, det);
    done <= 1'b0;
    turn_on();
    i_mprs_host.pulse(0, OFF + 2);
    wait_for(det, 1'b1);
    repeat (DET + 4) @(posedge clk);
    check("pg_timeout", 1'b0, pg);
    print_verdict();
  end
endmodule : mprs_sequencer_test
